// File: dv/sspc_chk.sv
// Port checker of the serial port control
`timescale 1ns/1ps
module sspc_chk (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic shift_busy_i,
	input wire logic tmr_tick_i,
	input wire logic tx_load_o,
	input wire logic pins_to_port_o,
	input wire logic sck_o,
	input wire logic scl_oe_o,
	input wire logic ss_used_o,
	input wire logic i2c_slave_en_o,
	input wire logic i2c_addr10_o,
	input wire logic fw_master_o
);
	// Shadow of enable, polarity and mode
	logic [5:0] ctl_r;
	wire on = ctl_r[5];
	wire [3:0] md = ctl_r[3:0];
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			ctl_r <= 6'h00;
		else if (wr_i && addr_i == 3'h0)
			ctl_r <= wdata_i[5:0];
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	a_tx_not_busy: assert property (
		tx_load_o |-> $past(wr_i && addr_i == 3'h1 && !shift_busy_i)) else $error("load while busy");
	a_pins_need_en: assert property (
		!on |-> !pins_to_port_o) else $error("pins taken while off");
	a_ss_by_mode: assert property (
		on && md[3:1] == 3'h2 |-> ss_used_o == !md[0]) else $error("select use wrong");
	a_i2c_addr_width: assert property (
		on && md[3:1] == 3'h3 |-> i2c_slave_en_o && i2c_addr10_o == md[0]) else $error("i2c width");
	a_fw_master_idle: assert property (
		on && md == 4'hB |-> fw_master_o && !i2c_slave_en_o) else $error("fw master wrong");
	a_rsv_mode_off: assert property (
		md inside {4'h8, 4'hA, 4'hC, 4'hD} |-> !pins_to_port_o) else $error("reserved mode on");
	a_scl_stretch: assert property (
		i2c_slave_en_o |-> scl_oe_o == !ctl_r[4]) else $error("stretch wrong");
	// Needs four steady cycles so the divider phase has settled
	a_div4_rate: assert property (
		(on && md == 4'h0 && shift_busy_i && !wr_i) [*4] |-> sck_o != $past(sck_o, 2))
		else $error("clock not quarter rate");
	// Timer source: one clock toggle per timer tick
	a_tmr_half_rate: assert property (
		on && md == 4'h3 && shift_busy_i && !wr_i |=> sck_o == ($past(sck_o) ^ $past(tmr_tick_i)))
		else $error("timer clock rate wrong");
	c_tx: cover property (tx_load_o);
	c_stretch: cover property (scl_oe_o);
	c_spi_clk: cover property ((on && md == 4'h0 && shift_busy_i) [*4]);
	c_tmr_clk: cover property (on && md == 4'h3 && shift_busy_i && tmr_tick_i);
endmodule : sspc_chk
bind sspc_top sspc_chk sspc_chk_i (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .shift_busy_i,
	.tmr_tick_i,
	.tx_load_o, .pins_to_port_o, .sck_o, .scl_oe_o, .ss_used_o, .i2c_slave_en_o,
	.i2c_addr10_o, .fw_master_o);

// File: dv/sspc_peer.sv
// Behavioural shift engine and far-side peer
`timescale 1ns/1ps
module sspc_peer (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic go_i,
	input wire logic [3:0] len_i,
	input wire logic [7:0] data_i,
	output logic busy_o,
	output logic done_o,
	output logic [7:0] byte_o
);
	logic [3:0] cnt_r;
	logic [7:0] hold_r;
	// Byte only valid in the done pulse, inverted so stale data never matches
	assign byte_o = done_o ? hold_r : ~hold_r;
	assign busy_o = cnt_r != 4'h0;
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			cnt_r <= 4'h0;
			done_o <= 1'b0;
			hold_r <= 8'h00;
		end
		else
		begin
			done_o <= cnt_r == 4'h1;
			if (go_i && !busy_o)
			begin
				cnt_r <= len_i;
				hold_r <= data_i;
			end
			else if (busy_o)
				cnt_r <= cnt_r - 4'h1;
		end
	end
endmodule : sspc_peer

// File: dv/tb_top.sv
// Self-checking bench of the serial port control
`timescale 1ns/1ps
module tb_top;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [2:0] addr_i = 3'h0;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0, rd_i = 1'b0, start_det_i = 1'b0, stop_det_i = 1'b0, tmr_tick_i = 1'b0;
	logic go = 1'b0;
	logic [3:0] len = 4'h1;
	logic [7:0] pdat = 8'h00;
	logic shift_busy_i, byte_done_i, tx_load_o, pins_to_port_o, sck_o, scl_oe_o, ss_used_o;
	logic i2c_slave_en_o, i2c_addr10_o, fw_master_o, irq_o, sck_oe_o, scl_o;
	logic [7:0] rx_byte_i, rdata_o, tx_data_o, slave_addr_o, addr_mask_o, d, a, b;
	int fails = 0, comparisons = 0, cyc = 0;
	sspc_top sspc_top_i (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .shift_busy_i,
		.byte_done_i, .rx_byte_i, .start_det_i, .stop_det_i, .tmr_tick_i, .tx_load_o, .tx_data_o,
		.pins_to_port_o, .sck_o, .sck_oe_o, .scl_o, .scl_oe_o, .ss_used_o, .i2c_slave_en_o,
		.i2c_addr10_o, .fw_master_o, .slave_addr_o, .addr_mask_o, .irq_o);
	sspc_peer sspc_peer_i (.clk_i, .rstn_i, .go_i(go), .len_i(len), .data_i(pdat),
		.busy_o(shift_busy_i), .done_o(byte_done_i), .byte_o(rx_byte_i));
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		forever #12.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		tmr_tick_i <= 1'($urandom % 3 == 0);
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fails++;
			summarize();
		end
	end
	task automatic summarize();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [2:0] ad, input logic [7:0] v);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= ad;
		wdata_i <= v;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [2:0] ad);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= ad;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd
	// Optional buffer write lands while the word is still shifting
	task automatic xfer(input logic [7:0] v, input logic [3:0] n, input bit hit);
		@(posedge clk_i);
		go <= 1'b1;
		len <= n;
		pdat <= v;
		@(posedge clk_i);
		go <= 1'b0;
		if (hit)
			wr(3'h1, ~v);
		for (int i = 0; i < 20 && !byte_done_i; i++)
			@(posedge clk_i);
		#1;
	endtask : xfer
	function automatic logic [7:0] mexp(input int m);
		return {3'h0, m inside {6, 7, 14, 15}, m == 11, m == 7 || m == 15, m == 4,
			!(m inside {8, 10, 12, 13})};
	endfunction : mexp
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(43));
		repeat (5) @(posedge clk_i);
		rstn_i <= 1'b1;
		rd(3'h0);
		chk("ctrl", 8'h00, d);
		wr(3'h6, 8'hFF);
		rd(3'h6);
		chk("unmapped", 8'h00, d);
		$display("test reset done");
		for (int m = 0; m < 16; m++)
		begin
			wr(3'h0, 8'h20 | 8'(m));
			chk("mode", mexp(m), {3'h0, i2c_slave_en_o, fw_master_o, i2c_addr10_o,
				ss_used_o, pins_to_port_o});
		end
		wr(3'h0, 8'h06);
		chk("pins_off", 8'h00, {7'h00, pins_to_port_o});
		a = 8'($urandom);
		wr(3'h0, 8'h26);
		wr(3'h2, a);
		chk("saddr", a, slave_addr_o);
		chk("stretch", 8'h01, {7'h00, scl_oe_o});
		chk("scl_low", 8'h00, {7'h00, scl_o});
		chk("sck_oe_off", 8'h00, {7'h00, sck_oe_o});
		wr(3'h0, 8'h29);
		wr(3'h2, ~a);
		chk("amask", ~a, addr_mask_o);
		chk("saddr_kept", a, slave_addr_o);
		$display("test modes done");
		wr(3'h0, 8'h30);
		repeat (2) @(posedge clk_i);
		chk("sck_idle_hi", 8'h01, {7'h00, sck_o});
		wr(3'h0, 8'h20);
		repeat (2) @(posedge clk_i);
		chk("sck_idle_lo", 8'h00, {7'h00, sck_o});
		chk("sck_oe", 8'h01, {7'h00, sck_oe_o});
		wr(3'h1, a);
		chk("tx_load", 8'h01, {7'h00, tx_load_o});
		chk("tx_data", a, tx_data_o);
		xfer(8'hC3, 4'h8, 1'b1);
		rd(3'h0);
		chk("write_collision_flag", 8'hA0, d);
		wr(3'h0, 8'h20);
		rd(3'h0);
		chk("write_collision_flag_clr", 8'h20, d);
		rd(3'h1);
		chk("buf", 8'hC3, d);
		chk("tx_kept", a, tx_data_o);
		$display("test collision done");
		for (int k = 0; k < 3; k++)
		begin
			// Masters overwrite, the slave modes keep the first byte and flag overflow
			wr(3'h0, k == 0 ? 8'h20 : k == 1 ? 8'h24 : 8'h26);
			xfer(8'h11, 4'h1, 1'b0);
			xfer(8'h22, 4'h3, 1'b0);
			rd(3'h0);
			chk("ov", k == 0 ? 8'h20 : 8'h40 | (k == 1 ? 8'h24 : 8'h26), d);
			rd(3'h1);
			chk("ov_buf", k == 0 ? 8'h22 : 8'h11, d);
			rd(3'h0);
			chk("ov_sticky", k == 0 ? 8'h20 : 8'h40 | (k == 1 ? 8'h24 : 8'h26), d);
		end
		wr(3'h0, 8'h26);
		rd(3'h0);
		chk("ov_clr", 8'h26, d);
		$display("test overflow done");
		rd(3'h4);
		wr(3'h5, 8'h01);
		xfer(8'h5A, 4'h2, 1'b0);
		chk("irq_on", 8'h01, {7'h00, irq_o});
		rd(3'h4);
		chk("istat", 8'h01, d);
		chk("irq_clr", 8'h00, {7'h00, irq_o});
		wr(3'h0, 8'h3E);
		chk("scl_release", 8'h00, {7'h00, scl_oe_o});
		wr(3'h5, 8'h18);
		@(posedge clk_i);
		start_det_i <= 1'b1;
		stop_det_i <= 1'b1;
		@(posedge clk_i);
		start_det_i <= 1'b0;
		stop_det_i <= 1'b0;
		#1;
		chk("irq_bus", 8'h01, {7'h00, irq_o});
		rd(3'h4);
		chk("istat_bus", 8'h18, d);
		$display("test irq done");
		// Divide by 16: first rise eight cycles after the shift starts
		wr(3'h0, 8'h21);
		@(posedge clk_i);
		go <= 1'b1;
		len <= 4'hF;
		@(posedge clk_i);
		go <= 1'b0;
		repeat (7) @(posedge clk_i);
		#1;
		chk("sck16_lo", 8'h00, {7'h00, sck_o});
		@(posedge clk_i);
		#1;
		chk("sck16_hi", 8'h01, {7'h00, sck_o});
		repeat (9) @(posedge clk_i);
		// Timer source, rate checked by the checker
		wr(3'h0, 8'h23);
		xfer(8'h00, 4'hF, 1'b0);
		$display("test divider done");
		wr(3'h0, 8'h20);
		for (int k = 0; k < 20; k++)
		begin
			b = 8'($urandom);
			xfer(b, 4'(1 + $urandom % 8), 1'b0);
			rd(3'h1);
			chk("rand_buf", b, d);
		end
		$display("test random done");
		summarize();
	end
endmodule : tb_top

// File: rtl/sspc_clkdiv.sv
// Master serial clock divider
`timescale 1ns/1ps
`include "sspc_consts.svh"
module sspc_clkdiv (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic run_i,
	input wire sspc_pkg::sspc_div_t sel_i,
	input wire logic tmr_tick_i,
	input wire logic idle_high_i,
	output logic sck_o
);

	logic [5:0] cnt_r;
	logic [5:0] cnt_nxt;
	logic phase_r;
	logic phase_nxt;
	logic [5:0] half;
	logic hit;

	assign half = (sel_i == sspc_pkg::SSPC_DIV4) ? `SSPC_HALF_DIV4 :
		(sel_i == sspc_pkg::SSPC_DIV16) ? `SSPC_HALF_DIV16 : `SSPC_HALF_DIV64;
	// Timer source halves its output: one toggle per tick
	assign hit = (sel_i == sspc_pkg::SSPC_DIVTMR) ? tmr_tick_i : (cnt_r == half);
	assign cnt_nxt = (!run_i || hit) ? 6'h00 : cnt_r + 6'h01;
	assign phase_nxt = run_i ? (phase_r ^ hit) : 1'b0;
	// Idle level follows the polarity bit
	assign sck_o = phase_r ^ idle_high_i;

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			cnt_r <= 6'h00;
			phase_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			phase_r <= phase_nxt;
		end
	end

endmodule : sspc_clkdiv

// File: rtl/sspc_consts.svh
// Offsets, field positions, reset values and timing counts of the serial port control
`ifndef SSPC_CONSTS_SVH
`define SSPC_CONSTS_SVH

// Register offsets
`define SSPC_OFF_CTRL 3'h0
`define SSPC_OFF_BUF 3'h1
`define SSPC_OFF_SADDR 3'h2
`define SSPC_OFF_AMASK 3'h3
`define SSPC_OFF_ISTAT 3'h4
`define SSPC_OFF_IMASK 3'h5

// Control register fields
`define SSPC_BIT_WRITE_COLLISION_FLAG 7
`define SSPC_BIT_OV 6
`define SSPC_BIT_EN 5
`define SSPC_BIT_CKP 4
`define SSPC_MODE_HI 3

// Interrupt status fields
`define SSPC_IRQ_DONE 0
`define SSPC_IRQ_WRITE_COLLISION_FLAG 1
`define SSPC_IRQ_OV 2
`define SSPC_IRQ_START 3
`define SSPC_IRQ_STOP 4
`define SSPC_IRQ_W 5

// Reset values
`define SSPC_RST_CTRL 8'h00
`define SSPC_RST_BYTE 8'h00
`define SSPC_RST_IMASK 5'h00

// Master clock dividers: terminal counts, one less than the half period in oscillator cycles
`define SSPC_HALF_DIV4 6'h01
`define SSPC_HALF_DIV16 6'h07
`define SSPC_HALF_DIV64 6'h1F

`endif

// File: rtl/sspc_pkg.sv
// Types of the serial port control
package sspc_pkg;

	typedef enum logic [3:0] {
		SSPC_SPI_M4 = 4'h0,
		SSPC_SPI_M16 = 4'h1,
		SSPC_SPI_M64 = 4'h2,
		SSPC_SPI_MTMR = 4'h3,
		SSPC_SPI_S_SS = 4'h4,
		SSPC_SPI_S_NOSS = 4'h5,
		SSPC_I2C_S7 = 4'h6,
		SSPC_I2C_S10 = 4'h7,
		SSPC_RSV8 = 4'h8,
		SSPC_MASK_LOAD = 4'h9,
		SSPC_RSVA = 4'hA,
		SSPC_I2C_FWM = 4'hB,
		SSPC_RSVC = 4'hC,
		SSPC_RSVD = 4'hD,
		SSPC_I2C_S7_SP = 4'hE,
		SSPC_I2C_S10_SP = 4'hF
	} sspc_mode_t;

	typedef enum logic [1:0] {
		SSPC_DIV4 = 2'h0,
		SSPC_DIV16 = 2'h1,
		SSPC_DIV64 = 2'h2,
		SSPC_DIVTMR = 2'h3
	} sspc_div_t;

endpackage : sspc_pkg

// File: rtl/sspc_sticky.sv
// Sticky flag vector, set wins over clear
`timescale 1ns/1ps
module sspc_sticky #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [W-1:0] set_i,
	input wire logic [W-1:0] clr_i,
	output logic [W-1:0] q_o
);

	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;

	// A set in the clearing cycle must not be lost
	assign q_nxt = set_i | (q_r & ~clr_i);
	assign q_o = q_r;

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			q_r <= '0;
		else
			q_r <= q_nxt;
	end

endmodule : sspc_sticky

// File: rtl/sspc_top.sv
// Control and status logic of the synchronous serial port
// Function
// [RULE_01] Buffer write while shifting sets collision flag
// [RULE_02] SPI unread byte: set overflow, drop byte
// [RULE_03] SPI overflow only as slave, never master
// [RULE_04] Transmit-only slave software still reads buffer
// [RULE_05] I2C unread byte sets overflow flag
// [RULE_06] Overflow stays until software clears it
// [RULE_07] Enable bit hands SPI pins to port
// [RULE_08] Software sets pin directions when enabled
// [RULE_09] SPI polarity bit picks clock idle level
// [RULE_10] I2C polarity bit releases or stretches clock
// [RULE_11] Mode 0000: SPI master, oscillator over four
// [RULE_12] Other master modes: /16, /64, timer/2
// [RULE_13] SPI slave modes: with or without select
// [RULE_14] Modes 0110/0111: I2C slave 7/10-bit
// [RULE_15] Mode 1001 redirects address writes to mask
// [RULE_16] Mode 1011: firmware I2C master, slave idle
// [RULE_17] Start/stop interrupt I2C slave modes
// [RULE_18] Reserved modes behave as port disabled
`timescale 1ns/1ps
`include "sspc_consts.svh"
module sspc_top (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic shift_busy_i,
	input wire logic byte_done_i,
	input wire logic [7:0] rx_byte_i,
	input wire logic start_det_i,
	input wire logic stop_det_i,
	input wire logic tmr_tick_i,
	output logic tx_load_o,
	output logic [7:0] tx_data_o,
	output logic pins_to_port_o,
	output logic sck_o,
	output logic sck_oe_o,
	output logic scl_o,
	output logic scl_oe_o,
	output logic ss_used_o,
	output logic i2c_slave_en_o,
	output logic i2c_addr10_o,
	output logic fw_master_o,
	output logic [7:0] slave_addr_o,
	output logic [7:0] addr_mask_o,
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////////////
	// Registers

	logic [5:0] ctrl_r;
	logic [7:0] buf_r;
	logic buf_full_r;
	logic [7:0] saddr_r;
	logic [7:0] amask_r;
	logic [4:0] imask_r;
	logic [7:0] rdata_r;
	logic tx_load_r;
	logic [7:0] tx_data_r;

	logic [5:0] ctrl_nxt;
	logic [7:0] buf_nxt;
	logic buf_full_nxt;
	logic [7:0] saddr_nxt;
	logic [7:0] amask_nxt;
	logic [4:0] imask_nxt;
	logic [7:0] rdata_nxt;

	////////////////////////////////////////////////////////////////////////////
	// Mode decode

	sspc_pkg::sspc_mode_t mode;
	logic en;
	logic clock_polarity_release_bit;
	logic is_master;
	logic is_spi_slave;
	logic is_i2c_slave;
	logic is_fwm;
	logic is_i2c;
	logic is_sp_irq;
	logic is_spi;
	logic legal;
	sspc_pkg::sspc_div_t div_sel;

	assign mode = sspc_pkg::sspc_mode_t'(ctrl_r[`SSPC_MODE_HI:0]);
	assign en = ctrl_r[`SSPC_BIT_EN];
	assign clock_polarity_release_bit = ctrl_r[`SSPC_BIT_CKP];
	// [RULE_11] Master mode codes
	assign is_master = (mode == sspc_pkg::SSPC_SPI_M4) || (mode == sspc_pkg::SSPC_SPI_M16) ||
		(mode == sspc_pkg::SSPC_SPI_M64) || (mode == sspc_pkg::SSPC_SPI_MTMR);
	// [RULE_13] Slave clock from pin
	assign is_spi_slave = (mode == sspc_pkg::SSPC_SPI_S_SS) || (mode == sspc_pkg::SSPC_SPI_S_NOSS);
	// [RULE_14] I2C slave addressing
	assign is_i2c_slave = (mode == sspc_pkg::SSPC_I2C_S7) || (mode == sspc_pkg::SSPC_I2C_S10) ||
		(mode == sspc_pkg::SSPC_I2C_S7_SP) || (mode == sspc_pkg::SSPC_I2C_S10_SP);
	// [RULE_16] Firmware master, slave logic idle
	assign is_fwm = (mode == sspc_pkg::SSPC_I2C_FWM);
	// [RULE_17] Start and stop events reported
	assign is_sp_irq = (mode == sspc_pkg::SSPC_I2C_S7_SP) || (mode == sspc_pkg::SSPC_I2C_S10_SP);
	assign is_i2c = is_i2c_slave || is_fwm || (mode == sspc_pkg::SSPC_MASK_LOAD);
	assign is_spi = is_master || is_spi_slave;
	// [RULE_18] Reserved codes keep port off
	assign legal = is_spi || is_i2c;
	// [RULE_12] Divider source select
	assign div_sel = sspc_pkg::sspc_div_t'(ctrl_r[1:0]);

	////////////////////////////////////////////////////////////////////////////
	// Bus decode

	logic wr_ctrl;
	logic wr_buf;
	logic wr_saddr;
	logic wr_amask;
	logic wr_imask;
	logic rd_buf;
	logic rd_istat;
	logic rd_ctrl;
	logic rd_saddr;
	logic rd_amask;
	logic rd_imask;
	logic redirect;

	// [RULE_15] Address location feeds the mask
	assign redirect = (mode == sspc_pkg::SSPC_MASK_LOAD);
	assign wr_ctrl = wr_i && (addr_i == `SSPC_OFF_CTRL);
	assign wr_buf = wr_i && (addr_i == `SSPC_OFF_BUF);
	assign wr_saddr = wr_i && (addr_i == `SSPC_OFF_SADDR) && !redirect;
	assign wr_amask = wr_i && (((addr_i == `SSPC_OFF_SADDR) && redirect) ||
		(addr_i == `SSPC_OFF_AMASK));
	assign wr_imask = wr_i && (addr_i == `SSPC_OFF_IMASK);
	assign rd_buf = rd_i && (addr_i == `SSPC_OFF_BUF);
	assign rd_istat = rd_i && (addr_i == `SSPC_OFF_ISTAT);
	assign rd_ctrl = rd_i && (addr_i == `SSPC_OFF_CTRL);
	assign rd_saddr = rd_i && (addr_i == `SSPC_OFF_SADDR);
	assign rd_amask = rd_i && (addr_i == `SSPC_OFF_AMASK);
	assign rd_imask = rd_i && (addr_i == `SSPC_OFF_IMASK);

	////////////////////////////////////////////////////////////////////////////
	// Collision and overflow

	logic active;
	logic collide;
	logic tx_ok;
	logic ov_cond;
	logic take_byte;
	logic write_collision_flag;
	logic ov;
	logic [1:0] flag_set;
	logic [1:0] flag_clr;
	logic [1:0] flag_q;

	assign active = en && legal;
	// [RULE_01] Write during shift collides
	assign collide = wr_buf && shift_busy_i;
	assign tx_ok = wr_buf && !shift_busy_i;
	// [RULE_03] Master cannot overrun, it starts each byte
	// [RULE_02] Slave overrun drops the new byte
	// [RULE_05] I2C overrun on unread byte
	assign ov_cond = active && byte_done_i && buf_full_r && !rd_buf && (is_spi_slave || is_i2c);
	assign take_byte = active && byte_done_i && !ov_cond;
	assign flag_set = {collide, ov_cond};
	// [RULE_06] Only a software write of zero clears
	assign flag_clr = {wr_ctrl && !wdata_i[`SSPC_BIT_WRITE_COLLISION_FLAG], wr_ctrl && !wdata_i[`SSPC_BIT_OV]};
	assign write_collision_flag = flag_q[1];
	assign ov = flag_q[0];

	sspc_sticky #(
		.W(2)
	) u_flags (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.set_i(flag_set),
		.clr_i(flag_clr),
		.q_o(flag_q)
	);

	////////////////////////////////////////////////////////////////////////////
	// Interrupt status

	logic [4:0] ev;
	logic [4:0] istat;

	assign ev[`SSPC_IRQ_DONE] = take_byte;
	assign ev[`SSPC_IRQ_WRITE_COLLISION_FLAG] = collide;
	assign ev[`SSPC_IRQ_OV] = ov_cond;
	assign ev[`SSPC_IRQ_START] = active && is_sp_irq && start_det_i;
	assign ev[`SSPC_IRQ_STOP] = active && is_sp_irq && stop_det_i;

	// Read clears, but an event in that cycle survives
	sspc_sticky #(
		.W(`SSPC_IRQ_W)
	) u_istat (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.set_i(ev),
		.clr_i({`SSPC_IRQ_W{rd_istat}}),
		.q_o(istat)
	);

	assign irq_o = |(istat & imask_r);

	////////////////////////////////////////////////////////////////////////////
	// Next state

	logic [7:0] ctrl_rd;

	assign ctrl_rd = {write_collision_flag, ov, ctrl_r};
	assign ctrl_nxt = wr_ctrl ? wdata_i[5:0] : ctrl_r;
	// Collided writes are dropped so the word in flight stays intact
	assign buf_nxt = take_byte ? rx_byte_i : (tx_ok ? wdata_i : buf_r);
	assign buf_full_nxt = take_byte || (buf_full_r && !rd_buf);
	assign saddr_nxt = wr_saddr ? wdata_i : saddr_r;
	assign amask_nxt = wr_amask ? wdata_i : amask_r;
	assign imask_nxt = wr_imask ? wdata_i[4:0] : imask_r;
	// Unmapped or idle reads return zero
	assign rdata_nxt = rd_ctrl ? ctrl_rd :
		rd_buf ? buf_r :
		rd_saddr ? saddr_r :
		rd_amask ? amask_r :
		rd_istat ? {3'h0, istat} :
		rd_imask ? {3'h0, imask_r} : 8'h00;

	// Software-visible settings; flag bits live in the sticky cells
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			ctrl_r <= 6'(`SSPC_RST_CTRL);
			saddr_r <= `SSPC_RST_BYTE;
			amask_r <= `SSPC_RST_BYTE;
			imask_r <= `SSPC_RST_IMASK;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			saddr_r <= saddr_nxt;
			amask_r <= amask_nxt;
			imask_r <= imask_nxt;
		end
	end

	// Transfer buffer and its unread marker
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			buf_r <= `SSPC_RST_BYTE;
			buf_full_r <= 1'b0;
		end
		else
		begin
			buf_r <= buf_nxt;
			buf_full_r <= buf_full_nxt;
		end
	end

	// Registered outputs toward the bus and the shift engine
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			rdata_r <= 8'h00;
			tx_load_r <= 1'b0;
			tx_data_r <= 8'h00;
		end
		else
		begin
			rdata_r <= rdata_nxt;
			tx_load_r <= tx_ok && active;
			tx_data_r <= tx_ok ? wdata_i : tx_data_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pins

	logic mclk;

	// [RULE_09] Idle level from polarity bit
	sspc_clkdiv u_div (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.run_i(active && is_master && shift_busy_i),
		.sel_i(div_sel),
		.tmr_tick_i(tmr_tick_i),
		.idle_high_i(clock_polarity_release_bit),
		.sck_o(mclk)
	);

	// [RULE_07] Enable hands pins to the port
	assign pins_to_port_o = active;
	assign sck_o = mclk;
	// Direction bits still rule the pad; this only asks to drive
	assign sck_oe_o = active && is_master;
	// [RULE_10] Clock bit low stretches the line
	assign scl_o = 1'b0;
	assign scl_oe_o = active && is_i2c_slave && !clock_polarity_release_bit;
	assign ss_used_o = active && (mode == sspc_pkg::SSPC_SPI_S_SS);
	assign i2c_slave_en_o = active && is_i2c_slave;
	assign i2c_addr10_o = (mode == sspc_pkg::SSPC_I2C_S10) || (mode == sspc_pkg::SSPC_I2C_S10_SP);
	assign fw_master_o = active && is_fwm;
	assign tx_load_o = tx_load_r;
	assign tx_data_o = tx_data_r;
	assign slave_addr_o = saddr_r;
	assign addr_mask_o = amask_r;
	assign rdata_o = rdata_r;

endmodule : sspc_top
